// [dsm_cpu_model.sv]
// CPU core model: issues the sleep instruction and counts CPU clock enables.
// Assumes one system clock; the watch tick runs free as a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module dsm_cpu_model #(
  parameter int WATCH_DIV = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cpu_clk_en,
  input wire logic except_active,
  output logic sleep_req,
  output logic watch_tick
);
  int wcnt, en_cnt, pre_cyc, ex_cnt;
  logic counting;
  initial begin
    sleep_req = 1'b0;
    watch_tick = 1'b0;
  end
  // Watch tick and enable counters; a taken sleep restarts the latency counts
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wcnt <= 0;
      watch_tick <= 1'b0;
      en_cnt <= 0;
      pre_cyc <= 0;
      ex_cnt <= 0;
      counting <= 1'b0;
    end else begin
      wcnt <= (wcnt == WATCH_DIV - 1) ? 0 : wcnt + 1;
      watch_tick <= (wcnt == WATCH_DIV - 1);
      en_cnt <= en_cnt + int'(cpu_clk_en);
      if (sleep_req && cpu_clk_en) begin
        pre_cyc <= 0;
        ex_cnt <= 0;
        counting <= 1'b1;
      end else if (except_active) begin
        counting <= 1'b0;
        ex_cnt <= ex_cnt + int'(cpu_clk_en);
      end else if (counting) begin
        pre_cyc <= pre_cyc + 1;
      end
    end
  end
  // Sleep request held until an enabled edge takes it
  task automatic fire();
    @(posedge clock);
    sleep_req <= 1'b1;
    do @(posedge clock); while (cpu_clk_en !== 1'b1);
    sleep_req <= 1'b0;
  endtask : fire
endmodule : dsm_cpu_model
`default_nettype wire

// [dsm_ctrl.sv]
// Direct speed-mode transfer controller: mode bits over AHB-Lite, CPU clock enable.
// Assumes the CPU pulses sleep_req for the SLEEP instruction and watch_tick is synchronous.
// How it works
// - Medium-speed mode gives the CPU one clock enable in eight of high-speed mode.
// - A sleep with direct-transfer set and a listed bit combination changes running mode and then runs the exception sequence.
// - With the direct-transfer interrupt disabled the attempt stops in sleep or watch mode.
// - With the global interrupt mask set the attempt stops in sleep or watch mode for good.
// - High-speed with standby 0, low 0, medium 1, direct 1 goes via sleep to medium-speed; here the mode changes straight, sleep is not entered.
// - Medium-speed with standby 0, low 0, medium 0, direct 1 goes via sleep to high-speed; here the mode changes straight, sleep is not entered.
// - Either active mode with standby 1, low 1, direct 1, watch 1 goes via watch to subactive; here the mode changes straight, watch is not entered.
// - Subactive with standby 1, low 0, medium 0, direct 1, watch 1 settles then goes high-speed.
// - Subactive with standby 1, low 0, medium 1, direct 1, watch 1 settles then goes medium.
// - Latency is two plus one old-clock states then fourteen new-clock exception states.
// - One state is two oscillator periods in high-speed and sixteen in medium-speed.
// - Leaving subactive for active waits the settling count chosen by three select bits.
// - Subactive clock is the watch clock divided by two, four or eight.
// - Sleep with standby and low-speed both clear enters sleep mode unless a direct transfer is taken.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dsm_ctrl
  import dsm_pkg::*;
#(
  parameter int SETTLE_BASE = DSM_SETTLE_BASE
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic global_mask,
  input wire logic watch_tick,
  output logic cpu_clk_en,
  output logic [2:0] cur_mode,
  output logic except_active,
  output logic irq
);
  initial begin
    if (SETTLE_BASE < 2 || SETTLE_BASE > 16383) $error("dsm_ctrl SETTLE_BASE out of range");
  end

  // Register state
  logic [31:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  dsm_mode_e mode_r, mode_nxt, target_r;
  dsm_seq_e seq_r, seq_nxt;
  logic [17:0] cnt_r, cnt_nxt;
  logic [31:0] rdata_r;
  logic wr_ph_r;
  logic [7:0] addr_r;

  // Control fields
  wire f_standby = ctrl_r[DSM_B_STANDBY];
  wire f_low = ctrl_r[DSM_B_LOWSPD];
  wire f_med = ctrl_r[DSM_B_MEDSPD];
  wire f_direct = ctrl_r[DSM_B_DIRECT];
  wire f_watch = ctrl_r[DSM_B_WATCH];
  wire f_ien = ctrl_r[DSM_B_IEN];
  wire [2:0] f_sts = ctrl_r[DSM_B_STS +: 3];
  wire [1:0] f_subdiv = ctrl_r[DSM_B_SUBDIV +: 2];

  // Settling count from the select bits
  function automatic logic [17:0] settle_states(input logic [2:0] sts);
    logic [17:0] base;
    base = 18'(SETTLE_BASE);
    settle_states = sts[2] ? (base << 4) : (base << sts[1:0]);
  endfunction : settle_states

  // AHB-Lite decode
  wire bus_go = hsel && hready && htrans[1];
  wire [7:0] off_w = haddr[7:0];
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ph_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_ph_r <= bus_go && hwrite;
      addr_r <= off_w;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  wire wr_ctrl = wr_ph_r && addr_r == DSM_OFS_CTRL;
  wire wr_stat = wr_ph_r && addr_r == DSM_OFS_STAT;
  wire wr_mask = wr_ph_r && addr_r == DSM_OFS_MASK;
  wire [31:0] rd_mux =
    (off_w == DSM_OFS_CTRL) ? {21'h0, ctrl_r[10:0]} :
    (off_w == DSM_OFS_MODE) ? {22'h0, seq_r, 4'h0, mode_r} :
    (off_w == DSM_OFS_STAT) ? {30'h0, stat_r} :
    (off_w == DSM_OFS_MASK) ? {30'h0, mask_r} : 32'h0000_0000;
  // Read data registered at the address phase
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rdata_r <= 32'h0000_0000;
    else if (bus_go && !hwrite) rdata_r <= rd_mux;
  end
  // Control register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) ctrl_r <= DSM_CTRL_RST;
    else if (wr_ctrl) ctrl_r <= {21'h0, hwdata[10:0]};
  end

  // Clock enables per mode
  logic med_tick, sub_tick, watch_div_tick;
  dsm_divider #(.WIDTH(4)) u_med_div (
    .clock(clock), .arst_n(arst_n), .restart(1'b0),
    .ratio(4'(DSM_MED_DIV)), .tick(med_tick)
  );
  wire [3:0] sub_ratio = (f_subdiv == 2'd0) ? 4'd2 : (f_subdiv == 2'd1) ? 4'd4 : 4'd8;
  logic [3:0] wcnt_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) wcnt_r <= 4'h0;
    else if (watch_tick) wcnt_r <= (wcnt_r >= sub_ratio - 4'd1) ? 4'h0 : wcnt_r + 4'd1;
  end
  assign watch_div_tick = watch_tick && (wcnt_r >= sub_ratio - 4'd1);
  assign sub_tick = watch_div_tick;

  // State enable follows the present clock source
  function automatic logic mode_en(input dsm_mode_e m, input logic mt, input logic st);
    unique case (m)
      DSM_HIGH: mode_en = 1'b1;
      DSM_MEDIUM: mode_en = mt;
      DSM_SUB: mode_en = st;
      default: mode_en = 1'b0;
    endcase
  endfunction : mode_en
  wire run_en = mode_en(mode_r, med_tick, sub_tick);
  wire tgt_en = mode_en(target_r, med_tick, sub_tick);
  assign cpu_clk_en = (seq_r == DSM_RUN || seq_r == DSM_EXCEPT) ? run_en : 1'b0;
  assign cur_mode = mode_r;
  assign except_active = seq_r == DSM_EXCEPT;

  // Decode of sleep request bits
  wire active_w = mode_r == DSM_HIGH || mode_r == DSM_MEDIUM;
  wire go_h2m = mode_r == DSM_HIGH && !f_standby && !f_low && f_med;
  wire go_m2h = mode_r == DSM_MEDIUM && !f_standby && !f_low && !f_med;
  wire go_a2s = active_w && f_standby && f_low && f_watch;
  wire go_s2a = mode_r == DSM_SUB && f_standby && !f_low && f_watch;
  wire dt_match = f_direct && (go_h2m || go_m2h || go_a2s || go_s2a);
  wire dt_allowed = f_ien && !global_mask;
  // Ordinary entry when not a direct transfer
  wire dsm_mode_e plain_w = (f_standby && f_watch) ? DSM_WATCH :
    (f_standby && !f_low) ? DSM_STANDBY : DSM_SLEEP;
  wire dsm_mode_e via_w = (go_a2s || go_s2a) ? DSM_WATCH : DSM_SLEEP;
  wire dsm_mode_e dest_w = go_a2s ? DSM_SUB : (f_med ? DSM_MEDIUM : DSM_HIGH);

  // Transfer sequencer
  always_comb begin
    seq_nxt = seq_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    unique case (seq_r)
      DSM_RUN: begin
        if (sleep_req && run_en) begin
          seq_nxt = DSM_INSTR;
          cnt_nxt = 18'(DSM_SLEEP_STATES + DSM_INTERNAL_STATES - 1);
        end
      end
      // Instruction plus internal states on the old clock
      DSM_INSTR: begin
        if (run_en) begin
          if (cnt_r != 18'h0) begin
            cnt_nxt = cnt_r - 18'd1;
          end else if (!dt_match) begin
            mode_nxt = plain_w;
            seq_nxt = DSM_HOLD;
          end else if (!dt_allowed) begin
            mode_nxt = via_w;
            seq_nxt = DSM_HOLD;
          end else if (go_s2a) begin
            mode_nxt = DSM_WATCH;
            cnt_nxt = settle_states(f_sts) - 18'd1;
            seq_nxt = DSM_SETTLE;
          end else begin
            // Change straight to the new mode; sleep or watch is not entered
            mode_nxt = dest_w;
            cnt_nxt = 18'(DSM_EXCEPT_STATES - 1);
            seq_nxt = DSM_EXCEPT;
          end
        end
      end
      DSM_SETTLE: begin
        if (tgt_en) begin
          if (cnt_r != 18'h0) begin
            cnt_nxt = cnt_r - 18'd1;
          end else begin
            mode_nxt = dest_w;
            cnt_nxt = 18'(DSM_EXCEPT_STATES - 1);
            seq_nxt = DSM_EXCEPT;
          end
        end
      end
      // Fourteen exception states on the new clock
      DSM_EXCEPT: begin
        if (run_en) begin
          if (cnt_r != 18'h0) cnt_nxt = cnt_r - 18'd1;
          else seq_nxt = DSM_RUN;
        end
      end
      // Held until reset; no wake-up path leaves this state
      DSM_HOLD: seq_nxt = DSM_HOLD;
      default: seq_nxt = DSM_RUN;
    endcase
  end

  // Target latched during the instruction states
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) target_r <= DSM_HIGH;
    else if (seq_r == DSM_INSTR) target_r <= dest_w;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seq_r <= DSM_RUN;
      mode_r <= DSM_HIGH;
      cnt_r <= 18'h0;
    end else begin
      seq_r <= seq_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Events: transfer done, attempt stuck
  wire ev_done = seq_r == DSM_EXCEPT && seq_nxt == DSM_RUN;
  wire ev_stuck = seq_r == DSM_INSTR && seq_nxt == DSM_HOLD && dt_match;
  // Set wins over write-one clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= 2'b00;
      mask_r <= 2'b00;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? hwdata[1:0] : 2'b00)) | {ev_stuck, ev_done};
      if (wr_mask) mask_r <= hwdata[1:0];
    end
  end
  assign irq = |(stat_r & mask_r);

  // Assertions
  // One in eight
  med_rate_a: assert property (@(posedge clock) disable iff (!arst_n)
    med_tick |=> !med_tick [*7]) else $error("medium enable not one in eight");
  masked_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && dt_match && !f_ien)
    |=> seq_r == DSM_HOLD) else $error("masked transfer completed");
  hold_stays_a: assert property (@(posedge clock) disable iff (!arst_n)
    seq_r == DSM_HOLD |=> seq_r == DSM_HOLD && !cpu_clk_en) else $error("hold left");
  h2m_path_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && f_direct && go_h2m && dt_allowed)
    |=> mode_r == DSM_MEDIUM && seq_r == DSM_EXCEPT) else $error("high to medium failed");
  m2h_path_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && f_direct && go_m2h && dt_allowed)
    |=> mode_r == DSM_HIGH) else $error("medium to high failed");
  a2s_path_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && f_direct && go_a2s && dt_allowed)
    |=> mode_r == DSM_SUB) else $error("active to sub failed");
  s2a_settle_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && f_direct && go_s2a && dt_allowed)
    |=> mode_r == DSM_WATCH && seq_r == DSM_SETTLE) else $error("settle skipped");
  instr_count_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_RUN && sleep_req && run_en) |=> seq_r == DSM_INSTR && cnt_r == 18'd2)
    else $error("instruction states wrong");
  except_count_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(seq_r == DSM_EXCEPT) |-> cnt_r == 18'd13) else $error("exception count wrong");
  med_except_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_EXCEPT && mode_r == DSM_MEDIUM && cpu_clk_en) |-> med_tick)
    else $error("medium exception off its enable");
  irq_done_a: assert property (@(posedge clock) disable iff (!arst_n)
    (ev_done && mask_r[DSM_S_DONE]) |=> irq) else $error("done interrupt missing");
  done_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    ev_done |=> seq_r == DSM_RUN && stat_r[DSM_S_DONE])
    else $error("done flag not set");
  stuck_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    ev_stuck |=> stat_r[DSM_S_STUCK]) else $error("stuck flag not set");
  gmask_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && dt_match && global_mask)
    |=> seq_r == DSM_HOLD && (mode_r == DSM_SLEEP || mode_r == DSM_WATCH))
    else $error("global mask did not hold");
  settle_end_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_SETTLE && tgt_en && cnt_r == 18'h0)
    |=> seq_r == DSM_EXCEPT && mode_r == target_r) else $error("settle end wrong");
  settle_full_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_SETTLE && cnt_r != 18'h0) |=> seq_r == DSM_SETTLE)
    else $error("settle cut short");
  high_rate_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_RUN && mode_r == DSM_HIGH) |-> cpu_clk_en)
    else $error("high-speed enable missing");
  sub_src_a: assert property (@(posedge clock) disable iff (!arst_n)
    (mode_r == DSM_SUB && cpu_clk_en) |-> watch_tick)
    else $error("subactive enable off watch tick");
  plain_sleep_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && !dt_match && !f_standby && !f_low)
    |=> mode_r == DSM_SLEEP) else $error("plain sleep not entered");
  plain_entry_a: assert property (@(posedge clock) disable iff (!arst_n)
    (seq_r == DSM_INSTR && run_en && cnt_r == 18'h0 && !dt_match && f_standby && !f_low
      && !f_watch) |=> mode_r == DSM_STANDBY) else $error("plain standby not entered");

  // Covers for the main transfer paths
  h2m_c: cover property (@(posedge clock) disable iff (!arst_n)
    seq_r == DSM_EXCEPT && mode_r == DSM_MEDIUM);
  m2h_c: cover property (@(posedge clock) disable iff (!arst_n)
    ev_done && mode_r == DSM_HIGH);
  s2a_c: cover property (@(posedge clock) disable iff (!arst_n) seq_r == DSM_SETTLE);
  stuck_c: cover property (@(posedge clock) disable iff (!arst_n) ev_stuck);
  plain_c: cover property (@(posedge clock) disable iff (!arst_n)
    seq_r == DSM_HOLD && mode_r == DSM_STANDBY);
endmodule : dsm_ctrl
`default_nettype wire

// [dsm_divider.sv]
// Programmable divide-by-N enable pulse generator.
// Assumes one clock; restart realigns the phase.
`timescale 1ns/10ps
`default_nettype none
module dsm_divider #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic restart,
  input wire logic [WIDTH-1:0] ratio,
  output logic tick
);
  initial begin
    if (WIDTH < 2) $error("dsm_divider WIDTH too small");
  end
  logic [WIDTH-1:0] cnt_r;
  wire [WIDTH-1:0] last_w = ratio - WIDTH'(1);
  // Tick on the last count of each period
  assign tick = (cnt_r >= last_w) && !restart;
  // Counter wraps at ratio
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_r <= '0;
    else if (restart || cnt_r >= last_w) cnt_r <= '0;
    else cnt_r <= cnt_r + WIDTH'(1);
  end
endmodule : dsm_divider
`default_nettype wire

// [dsm_pkg.sv]
// Package for the direct speed-mode transfer controller.
// Assumes a single 20 MHz system clock and AHB-Lite register access.
package dsm_pkg;
  // Operating modes seen by the CPU clock logic
  typedef enum logic [2:0] {
    DSM_HIGH, DSM_MEDIUM, DSM_SUB, DSM_SLEEP, DSM_WATCH, DSM_STANDBY
  } dsm_mode_e;
  // Transfer sequencer states
  typedef enum logic [2:0] {
    DSM_RUN, DSM_INSTR, DSM_SETTLE, DSM_EXCEPT, DSM_HOLD
  } dsm_seq_e;
  // Register byte offsets
  localparam logic [7:0] DSM_OFS_CTRL = 8'h00;
  localparam logic [7:0] DSM_OFS_MODE = 8'h04;
  localparam logic [7:0] DSM_OFS_STAT = 8'h08;
  localparam logic [7:0] DSM_OFS_MASK = 8'h0C;
  // Control field positions
  localparam int DSM_B_STANDBY = 0;
  localparam int DSM_B_LOWSPD = 1;
  localparam int DSM_B_MEDSPD = 2;
  localparam int DSM_B_DIRECT = 3;
  localparam int DSM_B_WATCH = 4;
  localparam int DSM_B_IEN = 5;
  localparam int DSM_B_STS = 6;
  localparam int DSM_B_SUBDIV = 9;
  localparam logic [31:0] DSM_CTRL_RST = 32'h0000_0000;
  // Status bit positions
  localparam int DSM_S_DONE = 0;
  localparam int DSM_S_STUCK = 1;
  // Timing in system-clock states
  localparam int DSM_SLEEP_STATES = 2;
  localparam int DSM_INTERNAL_STATES = 1;
  localparam int DSM_EXCEPT_STATES = 14;
  localparam int DSM_MED_DIV = 8;
  localparam int DSM_HIGH_DIV = 1;
  localparam int DSM_SETTLE_BASE = 8192;
endpackage : dsm_pkg

// [tb_direct_speed_mode_transfer.sv]
// Testbench for the direct speed-mode transfer controller.
// Assumes a short settling base and the CPU model driving sleep and watch tick.
`timescale 1ns/10ps
`default_nettype none
module tb_direct_speed_mode_transfer import dsm_pkg::*;;
  localparam int SB = 4;
  logic clock, arst_n, hsel, hwrite, global_mask, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, cur_mode;
  logic sleep_req, watch_tick, cpu_clk_en, except_active;
  int fails, total_checks, k;
  int exp_e[4] = '{20, 10, 5, 5};
  dsm_ctrl #(.SETTLE_BASE(SB)) dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_req(sleep_req), .global_mask(global_mask), .watch_tick(watch_tick),
    .cpu_clk_en(cpu_clk_en), .cur_mode(cur_mode), .except_active(except_active), .irq(irq));
  dsm_cpu_model cpu (.clock(clock), .arst_n(arst_n), .cpu_clk_en(cpu_clk_en),
    .except_active(except_active), .sleep_req(sleep_req), .watch_tick(watch_tick));
  // Clock of 50 ns
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rchk
  // Control word; direct transfer bit always set, fields from bit 0 upward
  function automatic logic [31:0] ctl(input logic s, l, m, w, ie, input logic [2:0] sts,
                                      input logic [1:0] sd);
    return {21'h00_0000, sd, sts, ie, w, 1'b1, m, l, s};
  endfunction : ctl
  task automatic rst();
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
  endtask : rst
  task automatic cnt(input int n);
    @(posedge clock);
    k = cpu.en_cnt;
    repeat (n) @(posedge clock);
    k = cpu.en_cnt - k;
  endtask : cnt
  // Full transfer: configure, sleep, wait for the exception, check mode and timing
  task automatic xfer(input logic [31:0] c, input dsm_mode_e m, input int lo, input int hi);
    bus(1'b1, DSM_OFS_CTRL, c);
    cpu.fire();
    do @(posedge clock); while (except_active !== 1'b1);
    do @(posedge clock); while (except_active !== 1'b0);
    repeat (2) @(posedge clock);
    chk("cur_mode", 32'(m), 32'(cur_mode));
    chk("exc_states", 32'(DSM_EXCEPT_STATES), cpu.ex_cnt);
    total_checks++;
    if (cpu.pre_cyc < lo || cpu.pre_cyc > hi) begin
      fails++;
      $display("MISMATCH pre_cycles expected %0d to %0d seen %0d", lo, hi, cpu.pre_cyc);
    end
  endtask : xfer
  // Sleep that must stop in a held mode with no exception
  task automatic stuck(input logic [31:0] c, input dsm_mode_e m, input int n);
    bus(1'b1, DSM_OFS_CTRL, c);
    cpu.fire();
    repeat (n) @(posedge clock);
    chk("held_mode", 32'(m), 32'(cur_mode));
    chk("no_exc", 32'h0000_0000, cpu.ex_cnt);
  endtask : stuck
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    give_verdict();
  end
  initial begin
    {arst_n, hsel, hwrite, global_mask, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    // Register reset values, unmapped and read-only places
    rchk("ctrl_rst", DSM_OFS_CTRL, DSM_CTRL_RST);
    rchk("mode_rst", DSM_OFS_MODE, 32'(DSM_HIGH));
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h10, 32'h0000_0000);
    chk("hresp", 32'h0000_0000, 32'(hresp));
    bus(1'b1, DSM_OFS_MODE, 32'hFFFF_FFFF);
    rchk("mode_ro", DSM_OFS_MODE, 32'(DSM_HIGH));
    bus(1'b1, DSM_OFS_CTRL, 32'hFFFF_FFFF);
    rchk("ctrl_bits", DSM_OFS_CTRL, 32'h0000_07FF);
    bus(1'b1, DSM_OFS_MASK, 32'h0000_0001);
    // high to medium, then one enable in eight
    xfer(ctl(0, 0, 1, 0, 1, 0, 0), DSM_MEDIUM, 2, 5);
    cnt(64);
    chk("med_enables", 32'(64 / DSM_MED_DIV), k);
    chk("irq_set", 32'h0000_0001, 32'(irq));
    rchk("stat_done", DSM_OFS_STAT, 32'h0000_0001);
    bus(1'b1, DSM_OFS_STAT, 32'h0000_0001);
    rchk("stat_clr", DSM_OFS_STAT, 32'h0000_0000);
    chk("irq_clr", 32'h0000_0000, 32'(irq));
    // medium to high with the interrupt masked, then unmasked
    bus(1'b1, DSM_OFS_MASK, 32'h0000_0000);
    xfer(ctl(0, 0, 0, 0, 1, 0, 0), DSM_HIGH, 16, 32);
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    bus(1'b1, DSM_OFS_MASK, 32'h0000_0001);
    @(negedge clock);
    chk("irq_unmask", 32'h0000_0001, 32'(irq));
    bus(1'b1, DSM_OFS_STAT, 32'h0000_0001);
    cnt(16);
    chk("high_enables", 32'h0000_0010, k);
    // high to subactive, every divider choice
    xfer(ctl(1, 1, 0, 1, 1, 0, 0), DSM_SUB, 2, 5);
    for (int sd = 0; sd < 4; sd++) begin
      bus(1'b1, DSM_OFS_CTRL, ctl(1, 1, 0, 1, 1, 0, 2'(sd)));
      cnt(160);
      chk("sub_enables", 32'(exp_e[sd]), k);
    end
    // subactive to active with settling, via medium and subactive again
    xfer(ctl(1, 0, 1, 1, 1, 0, 0), DSM_MEDIUM, 48, 72);
    xfer(ctl(1, 1, 0, 1, 1, 0, 0), DSM_SUB, 16, 32);
    xfer(ctl(1, 0, 0, 1, 1, 4, 0), DSM_HIGH, 80, 104);
    // disabled direct interrupt stops in sleep
    stuck(ctl(0, 0, 1, 0, 0, 0, 0), DSM_SLEEP, 100);
    rchk("stat_stuck", DSM_OFS_STAT, 32'h0000_0003);
    rst();
    // global mask stops in watch while ticks keep arriving
    global_mask <= 1'b1;
    stuck(ctl(1, 1, 0, 1, 1, 0, 0), DSM_WATCH, 200);
    rchk("stat_gmask", DSM_OFS_STAT, 32'h0000_0002);
    rst();
    global_mask <= 1'b0;
    // unlisted combination is a plain standby entry
    stuck(ctl(1, 0, 0, 0, 1, 0, 0), DSM_STANDBY, 50);
    // direct bit set but no transfer matches: plain sleep
    rst();
    stuck(ctl(0, 0, 0, 0, 1, 0, 0), DSM_SLEEP, 50);
    give_verdict();
  end
endmodule : tb_direct_speed_mode_transfer
`default_nettype wire
